// >>> rtl/sntx_pkg.sv
/*
 * Shared constants for the single-wire nibble transmitter: register offsets,
 * field positions, reset values, protocol tick counts and the sequencer states.
 * Assumes a 32-bit AXI4-Lite register bus and a single 100 MHz clock.
 */
package sntx_pkg;
  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] SNTX_OFS_TICK = 8'h00;
  localparam logic [7:0] SNTX_OFS_PAUSE = 8'h04;
  localparam logic [7:0] SNTX_OFS_CONFIG = 8'h08;
  localparam logic [7:0] SNTX_OFS_IRQ_EN = 8'h0c;
  localparam logic [7:0] SNTX_OFS_IRQ_FLG = 8'h10;
  localparam logic [7:0] SNTX_OFS_TX_HOLDING_BUFFER = 8'h14;

  // Configuration register field positions.
  localparam int SNTX_CFG_INIT = 0;
  localparam int SNTX_CFG_TXEN = 1;
  localparam int SNTX_CFG_SINGLE = 2;
  localparam int SNTX_CFG_NIB_LO = 4;

  // Flag and enable bit positions, shared by both registers.
  localparam int SNTX_F_EMPTY = 0;
  localparam int SNTX_F_DONE = 1;
  localparam int SNTX_F_CAL = 2;
  localparam int SNTX_F_UNDER = 3;
  localparam int SNTX_F_PRISE = 4;

  // Flags reset together by stop, init-hold and error recovery.
  localparam logic [4:0] SNTX_FLG_GROUP = 5'h17;
  // Values after reset: message-done and buffer-empty come up set.
  localparam logic [4:0] SNTX_FLG_RST = 5'h03;
  localparam logic [2:0] SNTX_NIB_RST = 3'h6;
  localparam logic [13:0] SNTX_TICK_RST = 14'h0000;
  localparam logic [11:0] SNTX_PAUSE_LEN_RST = 12'h00c;

  // Protocol timing in ticks.
  localparam logic [11:0] SNTX_CAL_TICKS = 12'h038;
  localparam logic [11:0] SNTX_NIB_BASE = 12'h00c;
  localparam logic [11:0] SNTX_LOW_TICKS = 12'h005;

  // AXI response codes.
  localparam logic [1:0] SNTX_RESP_OKAY = 2'h0;
  localparam logic [1:0] SNTX_RESP_SLVERR = 2'h2;

  // Transmit sequencer states.
  typedef enum logic [2:0] {
    SNTX_INIT,
    SNTX_IDLE,
    SNTX_CAL,
    SNTX_NIB,
    SNTX_PAUSE,
    SNTX_ERR
  } sntx_state_e;
endpackage

// >>> rtl/sntx_pulse.sv
/*
 * One pulse period of the line encoder: a fixed low phase then high until the
 * programmed period in ticks has passed.
 * Assumes a one-cycle tick enable and a start that may share the cycle of done.
 */
module sntx_pulse #(
  parameter int LEN_W = 12
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Control from the sequencer.
  input wire logic tick,
  input wire logic start,
  input wire logic abort,
  input wire logic [LEN_W-1:0] len,
  // Pulse status.
  output logic line_low,
  output logic rise,
  output logic done
);
  import sntx_pkg::*;

  // Whole state of the period timer.
  typedef struct packed {
    logic active;
    logic low;
    logic [LEN_W-1:0] cnt;
    logic [LEN_W-1:0] len;
  } sntx_pulse_s;

  sntx_pulse_s s_q;
  sntx_pulse_s s_d;
  logic [LEN_W-1:0] cnt_inc;

  assign cnt_inc = s_q.cnt + 1'b1;
  assign line_low = s_q.low;
  // Edges are reported in the tick cycle so the sequencer can chain periods.
  assign rise = s_q.active && tick && s_q.low && (cnt_inc == LEN_W'(SNTX_LOW_TICKS));
  assign done = s_q.active && tick && (cnt_inc == s_q.len);

  // Next state: start beats the tick so a new period counts from the next tick.
  always_comb begin
    s_d = s_q;
    if (abort) begin
      s_d.active = 1'b0;
      s_d.low = 1'b0;
    end else if (start) begin
      s_d.active = 1'b1;
      s_d.low = 1'b1;
      s_d.cnt = '0;
      s_d.len = len;
    end else if (s_q.active && tick) begin
      s_d.cnt = cnt_inc;
      if (rise) begin
        s_d.low = 1'b0;
      end
      if (done) begin
        s_d.active = 1'b0;
      end
    end
  end

  // Registers the timer; the line is idle high after reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// >>> rtl/sntx_top.sv
/*
 * Transmit control of a single-wire nibble transmitter with an AXI4-Lite
 * register slave, tick divider, message sequencer and combined interrupt.
 * Assumes stop_req is a level from the power controller, held while the clock
 * keeps running for at least one cycle after it rises.
 */
// Overview of operation
// - Buffer copied to shift register, sent nibble-wise.
// - Buffer-empty set on each buffer-to-shift move.
// - Clearing buffer-empty marks new data valid.
// - Message-done set when CRC nibble ends.
// - Calibration-start set as calibration pulse begins.
// - Early scheme refills on done across pause.
// - Single-shot waits for buffer-empty clear.
// - One interrupt: any enabled flag set.
// - Init-hold clear enables, locks static settings.
// - Stop aborts message, resets flags, idles line.
// - After stop, silent until new data.
// - Pause-rise flag on pause rising edge.
// - Continuous without data halts at calibration end.
// - Stop resets flags; done and empty come up set.
// - No new interrupts while clock stopped.
// - Tick divides clock by prescale plus one.
// - Calibration, status, data, CRC, optional pause.
// - Single-shot idles after message without data.
// - Continuous underrun aborts into error, line idle.
module sntx_top (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response.
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read.
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // System and line.
  input wire logic stop_req,
  output logic tx_line,
  output logic irq
);
  import sntx_pkg::*;

  // Whole state of the block.
  typedef struct packed {
    sntx_state_e state;
    logic [13:0] tick_cnt;
    logic [13:0] tick_divider_reg;
    logic pause_en;
    logic [11:0] pause_len;
    logic init_hold_bit;
    logic tx_en;
    logic single;
    logic [2:0] nib_cnt;
    logic [4:0] irq_enable_reg;
    logic [4:0] irq_flag_reg;
    logic [31:0] tx_holding_buffer;
    logic [3:0] stat_nib;
    logic [3:0] crc_nib;
    logic [23:0] data_sh;
    logic [2:0] nib_idx;
    logic stop_q;
    logic aw_ok;
    logic [7:0] aw_addr;
    logic w_ok;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sntx_state_s;

  sntx_state_s s_q;
  sntx_state_s s_d;
  logic tick; // One-cycle tick enable from the divider.
  logic p_start; // Starts the next pulse period.
  logic p_abort; // Kills the period in progress.
  logic [11:0] p_len; // Length of the next period in ticks.
  logic p_low; // Encoder holds the line low.
  logic p_rise; // Low phase just ended.
  logic p_done; // Period just ended.
  logic [31:0] wmask; // Byte-lane mask of the pending write.
  logic [31:0] wr_word; // Pending write merged into the old value.
  logic [31:0] rd_word; // Read data before registering.
  logic rd_hit; // Read address is mapped.
  logic wr_do; // Write is performed this cycle.
  logic [3:0] cur_nib; // Nibble value of the next period.

  // Period timer for calibration, nibble and pause pulses.
  sntx_pulse #(
    .LEN_W(12)
  ) u_pulse (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .start(p_start),
    .abort(p_abort),
    .len(p_len),
    .line_low(p_low),
    .rise(p_rise),
    .done(p_done)
  );

  // Tick runs only when enabled and not stopped; divisor is prescale plus one.
  assign tick = !s_q.init_hold_bit && !stop_req &&
    (s_q.tick_cnt == s_q.tick_divider_reg);
  assign tx_line = !p_low; // Idle level is high.
  // A stopped clock freezes the flags, so no new request can appear then.
  assign irq = |(s_q.irq_flag_reg & s_q.irq_enable_reg);
  assign s_axi_awready = !s_q.aw_ok && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_ok && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign wr_do = s_q.aw_ok && s_q.w_ok;

  // Byte-lane mask and merged write word for the addressed register.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{s_q.w_strb[i]}};
    end
    unique case (s_q.aw_addr)
      SNTX_OFS_TICK: wr_word = {18'h0, s_q.tick_divider_reg};
      SNTX_OFS_PAUSE: wr_word = {16'h0, s_q.pause_len, 3'h0, s_q.pause_en};
      SNTX_OFS_CONFIG: wr_word = {25'h0, s_q.nib_cnt, 1'b0, s_q.single, s_q.tx_en,
                                  s_q.init_hold_bit};
      SNTX_OFS_IRQ_EN: wr_word = {27'h0, s_q.irq_enable_reg};
      SNTX_OFS_TX_HOLDING_BUFFER: wr_word = s_q.tx_holding_buffer;
      default: wr_word = 32'h0;
    endcase
    wr_word = (wr_word & ~wmask) | (s_q.w_data & wmask);
  end

  // Read mux; unmapped addresses answer with a slave error.
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      SNTX_OFS_TICK: rd_word = {18'h0, s_q.tick_divider_reg};
      SNTX_OFS_PAUSE: rd_word = {16'h0, s_q.pause_len, 3'h0, s_q.pause_en};
      SNTX_OFS_CONFIG: rd_word = {25'h0, s_q.nib_cnt, 1'b0, s_q.single, s_q.tx_en,
                                  s_q.init_hold_bit};
      SNTX_OFS_IRQ_EN: rd_word = {27'h0, s_q.irq_enable_reg};
      SNTX_OFS_IRQ_FLG: rd_word = {27'h0, s_q.irq_flag_reg};
      SNTX_OFS_TX_HOLDING_BUFFER: rd_word = s_q.tx_holding_buffer;
      default: begin
        rd_word = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Nibble of the period after the current one: data from the shifter, CRC last.
  always_comb begin
    if (s_q.nib_idx == s_q.nib_cnt) begin
      cur_nib = s_q.crc_nib;
    end else if (s_q.nib_idx == 3'h0) begin
      cur_nib = s_q.data_sh[23:20];
    end else begin
      cur_nib = s_q.data_sh[19:16];
    end
  end

  // Next state: bus slave, register writes, flags and the message sequencer.
  always_comb begin
    logic [4:0] flg_set;
    logic [4:0] flg_clr;
    logic grp_rst;
    logic next_msg;
    s_d = s_q;
    flg_set = 5'h0;
    flg_clr = 5'h0;
    grp_rst = 1'b0;
    next_msg = 1'b0;
    p_start = 1'b0;
    p_abort = 1'b0;
    p_len = SNTX_CAL_TICKS;
    s_d.stop_q = stop_req;
    // Divider counts modulo prescale plus one.
    if (s_q.init_hold_bit || stop_req || tick) begin
      s_d.tick_cnt = 14'h0;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 14'h1;
    end
    // Address and data are taken independently, in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_ok = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_ok = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (wr_do) begin
      s_d.aw_ok = 1'b0;
      s_d.w_ok = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = SNTX_RESP_OKAY;
      unique case (s_q.aw_addr)
        SNTX_OFS_TICK: begin
          // Static settings are locked once init-hold is cleared.
          if (s_q.init_hold_bit) begin
            s_d.tick_divider_reg = wr_word[13:0];
          end
        end
        SNTX_OFS_PAUSE: begin
          if (s_q.init_hold_bit) begin
            s_d.pause_en = wr_word[0];
            s_d.pause_len = wr_word[15:4];
          end
        end
        SNTX_OFS_CONFIG: begin
          if (s_q.init_hold_bit) begin
            // New settings and the hold release land in one write.
            s_d.tx_en = wr_word[SNTX_CFG_TXEN];
            s_d.single = wr_word[SNTX_CFG_SINGLE];
            s_d.nib_cnt = wr_word[SNTX_CFG_NIB_LO +: 3];
            if (!wr_word[SNTX_CFG_INIT] && wr_word[SNTX_CFG_TXEN]) begin
              s_d.init_hold_bit = 1'b0;
              if (s_q.state == SNTX_INIT) begin
                s_d.state = SNTX_IDLE;
              end
            end
          end else if (wr_word[SNTX_CFG_INIT]) begin
            // Setting init-hold aborts; an open underrun keeps the error state.
            s_d.init_hold_bit = 1'b1;
            grp_rst = 1'b1;
            p_abort = 1'b1;
            s_d.state = s_q.irq_flag_reg[SNTX_F_UNDER] ? SNTX_ERR : SNTX_INIT;
          end
        end
        SNTX_OFS_IRQ_EN: s_d.irq_enable_reg = wr_word[4:0];
        SNTX_OFS_IRQ_FLG: begin
          // Flags clear on a one, inside enabled byte lanes only.
          flg_clr = s_q.w_data[4:0] & {5{s_q.w_strb[0]}};
          if (flg_clr[SNTX_F_UNDER] && s_q.state == SNTX_ERR) begin
            grp_rst = 1'b1;
            s_d.state = s_q.init_hold_bit ? SNTX_INIT : SNTX_IDLE;
          end
        end
        SNTX_OFS_TX_HOLDING_BUFFER: s_d.tx_holding_buffer = wr_word;
        default: s_d.bresp = SNTX_RESP_SLVERR;
      endcase
    end
    // Reads answer one cycle after the address is taken.
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_word;
      s_d.rresp = rd_hit ? SNTX_RESP_OKAY : SNTX_RESP_SLVERR;
    end
    // Message sequencer; it steps in every cycle, also while a bus write reconfigures the state.
    unique case (s_q.state)
      SNTX_INIT, SNTX_ERR: begin
        // Transmission disabled; only a bus write leaves these states.
      end
      SNTX_IDLE: begin
        // A cleared buffer-empty flag is the start trigger.
        if (!s_q.irq_flag_reg[SNTX_F_EMPTY] && !stop_req) begin
          next_msg = 1'b1;
        end
      end
      SNTX_CAL: begin
        if (p_done) begin
          if (s_q.irq_flag_reg[SNTX_F_EMPTY]) begin
            // No data at the end of calibration: halt with line idle.
            flg_set[SNTX_F_UNDER] = 1'b1;
            s_d.state = SNTX_ERR;
          end else begin
            // Only here, at the end of calibration, does the shifter load.
            s_d.stat_nib = s_q.tx_holding_buffer[31:28];
            s_d.crc_nib = s_q.tx_holding_buffer[27:24];
            s_d.data_sh = s_q.tx_holding_buffer[23:0];
            s_d.nib_idx = 3'h0;
            flg_set[SNTX_F_EMPTY] = 1'b1;
            p_start = 1'b1;
            p_len = SNTX_NIB_BASE + {8'h0, s_q.tx_holding_buffer[31:28]};
            s_d.state = SNTX_NIB;
          end
        end
      end
      SNTX_NIB: begin
        if (p_done) begin
          if (s_q.nib_idx == s_q.nib_cnt + 3'h1) begin
            flg_set[SNTX_F_DONE] = 1'b1;
            if (s_q.pause_en) begin
              p_start = 1'b1;
              p_len = s_q.pause_len;
              s_d.state = SNTX_PAUSE;
            end else begin
              next_msg = 1'b1;
            end
          end else begin
            // Advance; a data nibble just sent leaves the shifter.
            if (s_q.nib_idx != 3'h0) begin
              s_d.data_sh = {s_q.data_sh[19:0], 4'h0};
            end
            s_d.nib_idx = s_q.nib_idx + 3'h1;
            p_start = 1'b1;
            p_len = SNTX_NIB_BASE + {8'h0, cur_nib};
          end
        end
      end
      SNTX_PAUSE: begin
        if (p_rise) begin
          flg_set[SNTX_F_PRISE] = 1'b1;
        end
        if (p_done) begin
          next_msg = 1'b1;
        end
      end
    endcase
    // Boundary: single-shot without fresh data goes idle, else calibrate.
    if (next_msg) begin
      if (s_q.single && s_q.irq_flag_reg[SNTX_F_EMPTY]) begin
        s_d.state = SNTX_IDLE;
      end else begin
        p_start = 1'b1;
        p_len = SNTX_CAL_TICKS;
        flg_set[SNTX_F_CAL] = 1'b1;
        s_d.state = SNTX_CAL;
      end
    end
    // Stop entry aborts the message and idles the line before clocks halt.
    if (stop_req && !s_q.stop_q && s_q.state != SNTX_INIT && s_q.state != SNTX_ERR) begin
      p_abort = 1'b1;
      p_start = 1'b0;
      grp_rst = 1'b1;
      flg_set = 5'h0;
      s_d.state = SNTX_IDLE;
    end
    if (p_abort) begin
      p_start = 1'b0;
      flg_set = 5'h0;
      // A write raising init-hold decides the state over any sequencer step.
      if (s_d.init_hold_bit && !s_q.init_hold_bit) begin
        s_d.state = s_q.irq_flag_reg[SNTX_F_UNDER] ? SNTX_ERR : SNTX_INIT;
      end
    end
    // Clear first, then the group reset, and a hardware set wins over both.
    s_d.irq_flag_reg = s_q.irq_flag_reg & ~flg_clr;
    if (grp_rst) begin
      s_d.irq_flag_reg = (s_d.irq_flag_reg & ~SNTX_FLG_GROUP) |
        (SNTX_FLG_RST & SNTX_FLG_GROUP);
    end
    s_d.irq_flag_reg = s_d.irq_flag_reg | flg_set;
  end

  // Registers the whole state; reset enters init with flags at reset values.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.state <= SNTX_INIT;
      s_q.init_hold_bit <= 1'b1;
      s_q.irq_flag_reg <= SNTX_FLG_RST;
      s_q.nib_cnt <= SNTX_NIB_RST;
      s_q.tick_divider_reg <= SNTX_TICK_RST;
      s_q.pause_len <= SNTX_PAUSE_LEN_RST;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// >>> sim/sntx_rx.sv
/*
 * Receiver model on the serial line: it measures the spacing of falling
 * edges and the length of each low phase in clock cycles.
 * Assumes the line is sampled on the transmitter's own clock; it drives nothing.
 */
module sntx_rx (
  // Sampling clock.
  input wire logic aclk,
  // Serial line under observation.
  input wire logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  int n_fall = 0; // Falling edges seen so far.
  int cnt = 0; // Cycles since the last falling edge.
  int lcnt = 0; // Cycles since the line went low.
  int per[$]; // Fall-to-fall periods; the first one after idle is a gap.
  int low[$]; // Low phase lengths, pushed when the line rises.
  logic prev = 1'b1; // Line level at the previous edge.
  wire logic fall = prev === 1'b1 && line === 1'b0;
  // A receiver only listens, so an unknown level never counts as an edge.
  always @(posedge aclk) begin
    cnt <= fall ? 1 : cnt + 1;
    lcnt <= fall ? 1 : lcnt + 1;
    if (fall) begin
      per.push_back(cnt);
      n_fall <= n_fall + 1;
    end else if (prev === 1'b0 && line === 1'b1) begin
      low.push_back(lcnt);
    end
    prev <= line;
  end
endmodule

// >>> sim/sntx_top_checker.sv
/*
 * Port-level checks of the transmitter: bus answers, refusals, line timing
 * and quiet behaviour while the stop request is held.
 * Assumes it is bound to every instance of the transmitter top module.
 */
module sntx_top_checker import sntx_pkg::*; (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // System and line.
  input wire logic stop_req,
  input wire logic tx_line,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write halves taken together must be answered within two edges.
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  // A pending answer blocks new requests.
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  // Addresses past the last register answer with an error and zero data.
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
    |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == SNTX_RESP_SLVERR && s_axi_rdata == 0))
    else $error("unmapped read not refused");
  a_unmapped_write: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && s_axi_awaddr > 8'h14 |-> ##[1:2] (s_axi_bvalid &&
    s_axi_bresp == SNTX_RESP_SLVERR)) else $error("unmapped write not refused");
  // Every pulse period opens with a low phase of at least five clock cycles.
  a_low_phase: assert property ($fell(tx_line) |-> !tx_line [*5])
    else $error("low phase too short");
  // A held stop request keeps the line at idle and the interrupt frozen.
  a_stop_silent: assert property (stop_req [*4] |-> tx_line)
    else $error("line active in stop");
  a_irq_frozen: assert property (stop_req [*6] |-> $stable(irq))
    else $error("interrupt moved in stop");
  c_line_fall: cover property ($fell(tx_line));
  c_stop_entry: cover property ($rose(stop_req));
  c_bad_write: cover property (s_axi_bvalid && s_axi_bresp == SNTX_RESP_SLVERR);
endmodule

bind sntx_top sntx_top_checker i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .stop_req, .tx_line, .irq);

// >>> sim/tb_sntx_top.sv
/*
 * Self-checking bench: continuous messages with under-run, stop entry and
 * exit, then a single-shot message with pause at a random tick rate.
 * Assumes the response channels are always ready and full byte strobes.
 */
module tb_sntx_top import sntx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, stop_req = 1'b0;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic awr, wrd, bv, arr, rv, tx_line, irq;
  logic [1:0] br, rr;
  int failures = 0, n_compared = 0, seed = 51265;
  always #5 aclk = ~aclk;
  sntx_top i_sntx_top (.aclk, .aresetn, .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1), .s_axi_rdata(rdat), .s_axi_rresp(rr), .stop_req, .tx_line, .irq);
  sntx_rx i_sntx_rx (.aclk, .line(tx_line));
  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // A wait that runs out ends the run at once.
  task automatic tmo();
    chk(0, 1, "timeout");
    wrap_up();
  endtask
  // Write: address and data offered together, each dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er = SNTX_RESP_OKAY);
    int n;
    n = 0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (n < 40) begin
      @(posedge aclk);
      n++;
      if (bv === 1'b1) break;
      if (awr === 1'b1) awv <= 1'b0;
      if (wrd === 1'b1) wv <= 1'b0;
    end
    if (n == 40) tmo();
    chk(br, er, "bresp");
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'b1;
    while (n < 40) begin
      @(posedge aclk);
      n++;
      if (rv === 1'b1) break;
      if (arr === 1'b1) arv <= 1'b0;
    end
    if (n == 40) tmo();
    d = rdat;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er = SNTX_RESP_OKAY);
    logic [31:0] d;
    rd(a, d);
    chk(d, e, "rdata");
    chk(rr, er, "rresp");
  endtask
  // Polls the flag register until bit b is seen set.
  task automatic poll(input int b);
    logic [31:0] d;
    int n;
    n = 0;
    d = 32'h0;
    while (d[b] !== 1'b1 && n < 3000) begin
      rd(SNTX_OFS_IRQ_FLG, d);
      n++;
    end
    if (n == 3000) tmo();
  endtask
  task automatic wfall(input int f);
    int k;
    k = 0;
    while (i_sntx_rx.n_fall < f && k < 5000) begin
      @(posedge aclk);
      k++;
    end
    if (k == 5000) tmo();
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge aclk);
  endtask
  // Expected fall-to-fall cycles: calibration, status, first data, check nibble.
  function automatic int exp_per(input logic [31:0] w, input int i, input int k);
    case (i)
      0: return 56 * k;
      1: return (12 + w[31:28]) * k;
      2: return (12 + w[23:20]) * k;
      default: return (12 + w[27:24]) * k;
    endcase
  endfunction
  // The first calibration may start off the tick grid, so it gets a margin.
  task automatic cmsg(input int pi, input int li, input logic [31:0] w, input int k);
    int c;
    c = i_sntx_rx.per[pi];
    chk(c > exp_per(w, 0, k) - k && c < exp_per(w, 0, k) + k, 1, "calibration");
    for (int i = 1; i < 4; i++) begin
      chk(i_sntx_rx.per[pi + i], exp_per(w, i, k), "nibble period");
      chk(i_sntx_rx.low[li + i], 5 * k, "low phase");
    end
  endtask
  initial begin
    logic [31:0] wa, wb;
    int p, bp, bl, nf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(SNTX_OFS_CONFIG, 32'h61);
    rchk(SNTX_OFS_IRQ_FLG, 32'h03);
    rchk(SNTX_OFS_PAUSE, 32'hc0);
    rchk(8'h18, 32'h0, SNTX_RESP_SLVERR);
    wr(8'h18, 32'h1, SNTX_RESP_SLVERR);
    // Continuous mode, one data nibble, fastest tick, no pause.
    wr(SNTX_OFS_CONFIG, 32'h12);
    wr(SNTX_OFS_TICK, 32'h5);
    rchk(SNTX_OFS_TICK, 32'h0);
    wr(SNTX_OFS_IRQ_EN, 32'h1f);
    chk(irq, 1, "irq on reset flags");
    wr(SNTX_OFS_IRQ_EN, 32'h08);
    chk(irq, 0, "irq masked");
    wa = $random(seed);
    wb = $random(seed);
    bp = i_sntx_rx.per.size();
    bl = i_sntx_rx.low.size();
    wr(SNTX_OFS_TX_HOLDING_BUFFER, wa);
    wr(SNTX_OFS_IRQ_FLG, 32'h03);
    poll(SNTX_F_EMPTY);
    wr(SNTX_OFS_TX_HOLDING_BUFFER, wb);
    wr(SNTX_OFS_IRQ_FLG, 32'h01);
    // Third message is refilled on message-done, inside its own calibration.
    poll(SNTX_F_EMPTY);
    wr(SNTX_OFS_IRQ_FLG, 32'h02);
    poll(SNTX_F_DONE);
    wr(SNTX_OFS_TX_HOLDING_BUFFER, wa);
    wr(SNTX_OFS_IRQ_FLG, 32'h01);
    poll(SNTX_F_UNDER);
    chk(irq, 1, "irq raised");
    nf = i_sntx_rx.n_fall;
    rchk(SNTX_OFS_IRQ_FLG, 32'h0f);
    cmsg(bp + 1, bl, wa, 1);
    cmsg(bp + 5, bl + 4, wb, 1);
    cmsg(bp + 9, bl + 8, wa, 1);
    idle(200);
    chk(i_sntx_rx.n_fall, nf, "silent after underrun");
    chk(tx_line, 1, "idle level");
    wr(SNTX_OFS_IRQ_FLG, 32'h08);
    rchk(SNTX_OFS_IRQ_FLG, 32'h03);
    chk(irq, 0, "irq cleared");
    // Stop request in mid-message, clear of any low phase.
    bp = i_sntx_rx.n_fall;
    wr(SNTX_OFS_TX_HOLDING_BUFFER, $random(seed));
    wr(SNTX_OFS_IRQ_FLG, 32'h01);
    wfall(bp + 3);
    idle(8);
    stop_req <= 1'b1;
    idle(6);
    chk(tx_line, 1, "stop idles line");
    rchk(SNTX_OFS_IRQ_FLG, 32'h03);
    nf = i_sntx_rx.n_fall;
    idle(100);
    stop_req <= 1'b0;
    idle(100);
    chk(i_sntx_rx.n_fall, nf, "silent after stop");
    wr(SNTX_OFS_IRQ_FLG, 32'h01);
    wfall(nf + 2);
    idle(8);
    wr(SNTX_OFS_CONFIG, 32'h01);
    idle(3);
    chk(tx_line, 1, "init idles line");
    // Single-shot with pause at a slower random tick.
    p = 1 + ($random(seed) & 1);
    wr(SNTX_OFS_TICK, p);
    wr(SNTX_OFS_PAUSE, 32'h141);
    wr(SNTX_OFS_CONFIG, 32'h16);
    rchk(SNTX_OFS_CONFIG, 32'h16);
    wa = $random(seed);
    bp = i_sntx_rx.per.size();
    bl = i_sntx_rx.low.size();
    nf = i_sntx_rx.n_fall;
    wr(SNTX_OFS_TX_HOLDING_BUFFER, wa);
    wr(SNTX_OFS_IRQ_FLG, 32'h01);
    poll(SNTX_F_PRISE);
    rchk(SNTX_OFS_IRQ_FLG, 32'h17);
    cmsg(bp + 1, bl, wa, p + 1);
    idle(300);
    chk(i_sntx_rx.n_fall, nf + 5, "single shot stops");
    wrap_up();
  end
endmodule
